// ===== inc/adc_readout_pkg.sv
package adc_readout_pkg;

  // ----------------------------------------------------------------
  // Widths and formats
  // ----------------------------------------------------------------
  localparam int RESULT_W = 24;
  localparam int RAW_W    = 26;
  localparam int COUNT_W  = 5;
  localparam logic [RESULT_W-1:0] POS_FULL = 24'h7FFFFF;
  localparam logic [RESULT_W-1:0] NEG_FULL = 24'h800000;
  localparam logic [COUNT_W-1:0] CNT_IDLE   = 5'h1F;
  localparam logic [COUNT_W-1:0] CNT_FORCE  = 5'h18;
  localparam logic [COUNT_W-1:0] CNT_CAL    = 5'h1A;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int REF_CLK_HZ      = 2_000_000;
  localparam int REF_RATE_SPS    = 120;
  localparam int CONV_CYCLES_DEF = REF_CLK_HZ / REF_RATE_SPS;
  localparam int CAL_CYCLES_DEF  = 4 * CONV_CYCLES_DEF;
  localparam int STANDBY_HOLD_NS = 20_000;
  localparam int STANDBY_HOLD_CYCLES =
    (STANDBY_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int UPDATE_NS     = 10_000;
  localparam int UPDATE_CYCLES = (UPDATE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam logic [1:0] FILTER_SETTLE = 2'h2;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_RESULT  = 4'h8;
  localparam logic [3:0] REG_COUNT   = 4'hC;
  localparam int CTRL_CAL_POS   = 0;
  localparam int STAT_LINE_POS  = 0;
  localparam int STAT_CAL_POS   = 1;
  localparam int STAT_STBY_POS  = 2;
  localparam int STAT_STATE_POS = 4;
  localparam int STAT_CNT_POS   = 8;

  typedef enum {ST_CAL, ST_CONVERT, ST_READY, ST_STANDBY} ctrl_state_e;

  // Clips the wide filter output to the 24-bit two's complement range.
  function automatic logic [RESULT_W-1:0] saturate(input logic signed [RAW_W-1:0] raw);
    logic signed [RAW_W-1:0] hi;
    logic signed [RAW_W-1:0] lo;
    hi = RAW_W'(signed'(POS_FULL));
    lo = -hi - RAW_W'(1);
    if (raw > hi) begin
      saturate = POS_FULL;
    end else if (raw < lo) begin
      saturate = NEG_FULL;
    end else begin
      saturate = raw[RESULT_W-1:0];
    end
  endfunction

endpackage

// ===== inc/readout_if.sv
`timescale 1ns/1ps
interface readout_if;
  import adc_readout_pkg::*;
  logic                shift_level;
  logic                shift_rise;
  logic                shift_fall;
  logic [2:0]          pin_level;
  logic                pin_edge;
  logic                load;
  logic [RESULT_W-1:0] load_data;
  logic [COUNT_W-1:0]  bit_cnt;
  logic                msb;

  modport sync_side (output shift_level, shift_rise, shift_fall, pin_level, pin_edge);
  modport shift_side (input shift_rise, load, load_data, output bit_cnt, msb);
  modport ctrl_side (input shift_level, shift_rise, shift_fall, pin_level, pin_edge,
                     bit_cnt, msb, output load, load_data);
endinterface

// ===== rtl/adc_readout_ctrl.sv
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
// Functional notes
// RULE_01: Each rising shift clock edge puts the next result bit on the line.
// RULE_02: Select, buffer or sensor pin toggle restarts conversion, line high until settled.
// RULE_03: Toggling channel away and back resets the filter and restarts conversion.
// RULE_04: Host discards three readings after an abrupt input change without toggle.
// RULE_05: Result is 24-bit two's complement, sent most significant bit first.
// RULE_06: Result clips at positive and negative full scale; zero gives zero.
// RULE_07: Result rate scales with device clock, 120 per second at 2 MHz.
// RULE_08: Converts continuously and drives the line low for each new result.
// RULE_09: Host waits for low line, reads before the next update overwrites.
// RULE_10: Line keeps last shifted bit until driven high at next update.
// RULE_11: A 25th shift clock forces the line high.
// RULE_12: After forcing high, line stays high until the next result.
// RULE_13: Host gives at least two extra clocks to request calibration.
// RULE_14: Falling edge of the 26th shift clock starts calibration.
// RULE_15: Host may clock during calibration but should keep it minimal.
// RULE_16: Calibration end drives line low with a settled, valid result.
// RULE_17: Calibration disconnects inputs and applies internal signals.
// RULE_18: Calibration runs automatically after power-up.
// RULE_19: Shift clock held high for the hold time enters standby.
// RULE_20: Standby may be entered at any point of readback.
// RULE_21: Line stays high in standby; standby lasts while shift clock high.
// RULE_22: Shift clock low wakes the device, which converts a valid result.
// RULE_23: Host disables the input buffer during standby.
// RULE_24: Host may stop the device clock during standby.
// RULE_25: 25 bits then standby causes calibration on wakeup before ready.
// RULE_26: Channel select low picks the first pair, high the second.
// RULE_27: Host samples each bit on the falling shift clock edge.
module adc_readout_ctrl
  import adc_readout_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF,
  parameter int CAL_CYCLES  = CAL_CYCLES_DEF
) (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // Avalon-MM slave.
  input  wire logic [3:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  // Serial link pins.
  input  wire logic                      shift_clk,
  output logic                           ready_serial_out,
  // Input selection pins.
  input  wire logic                      channel_select_pin,
  input  wire logic                      input_buffer_enable_pin,
  input  wire logic                      temp_sensor_enable_pin,
  // Modulator and input front end.
  input  wire logic signed [RAW_W-1:0]   raw_sample,
  output logic                           input_pair_select,
  output logic                           buffer_on,
  output logic                           temp_sensor_route,
  output logic                           cal_inputs_disconnect,
  output logic                           standby_active
);

  readout_if ev ();

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  pin_sync #(.N(4)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .raw  ({temp_sensor_enable_pin, input_buffer_enable_pin, channel_select_pin, shift_clk}),
    .ev   (ev.sync_side)
  );

  result_shifter u_shift (
    .clk  (clk),
    .rstn (rstn),
    .sh   (ev.shift_side)
  );

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  localparam int UPDATE_START = CONV_CYCLES - UPDATE_CYCLES;

  ctrl_state_e state;
  ctrl_state_e next_state;
  logic        line;
  logic        next_line;
  logic [31:0] conv_cnt;
  logic [31:0] next_conv_cnt;
  logic [31:0] cal_cnt;
  logic [31:0] next_cal_cnt;
  logic [15:0] hold_cnt;
  logic [15:0] next_hold_cnt;
  logic [1:0]  settle;
  logic [1:0]  next_settle;
  logic        wake_cal;
  logic        next_wake_cal;
  logic [31:0] results;
  logic [31:0] next_results;
  logic        cal_req;
  logic        cal_trigger;
  logic        standby_go;

  assign cal_trigger = (ev.shift_fall && ev.bit_cnt == CNT_CAL) || cal_req; // [RULE_14]
  assign standby_go  = ev.shift_level
                       && hold_cnt == 16'(STANDBY_HOLD_CYCLES - 1); // [RULE_19] [RULE_20]
  assign ev.load_data = saturate(raw_sample); // [RULE_06]

  // Main sequencer. Reset lands in calibration, which doubles as power-up reset.
  always_comb begin
    next_state    = state;
    next_line     = line;
    next_conv_cnt = conv_cnt + 32'h1;
    next_cal_cnt  = cal_cnt;
    next_settle   = settle;
    next_wake_cal = wake_cal;
    next_results  = results;
    next_hold_cnt = (ev.shift_level && hold_cnt != 16'hFFFF) ? hold_cnt + 16'h1 : 16'h0;
    ev.load       = 1'b0;
    case (state)
      ST_CAL: begin
        next_line     = 1'b1;
        next_conv_cnt = '0;
        if (cal_cnt == 32'(CAL_CYCLES - 1)) begin
          ev.load      = 1'b1; // [RULE_16] [RULE_18]
          next_line    = 1'b0;
          next_state   = ST_READY;
          next_cal_cnt = '0;
          next_results = results + 32'h1;
        end else begin
          next_cal_cnt = cal_cnt + 32'h1;
        end
      end
      ST_STANDBY: begin
        next_line     = 1'b1; // [RULE_21]
        next_conv_cnt = '0;
        if (!ev.shift_level) begin
          next_wake_cal = 1'b0;
          next_cal_cnt  = '0;
          next_settle   = FILTER_SETTLE;
          next_state    = wake_cal ? ST_CAL : ST_CONVERT; // [RULE_22] [RULE_25]
        end
      end
      ST_CONVERT, ST_READY: begin
        if (cal_trigger) begin
          next_state   = ST_CAL;
          next_line    = 1'b1;
          next_cal_cnt = '0;
        end else if (ev.pin_edge) begin
          // Filter restart: the line stays high until settled data exists.
          next_state    = ST_CONVERT; // [RULE_02] [RULE_03]
          next_line     = 1'b1;
          next_conv_cnt = '0;
          next_settle   = FILTER_SETTLE;
        end else if (standby_go) begin
          next_state    = ST_STANDBY;
          next_line     = 1'b1;
          next_wake_cal = (ev.bit_cnt == CNT_CAL); // [RULE_25]
        end else begin
          if (state == ST_READY && ev.shift_rise) begin
            // Past bit 24 the line is forced high and stays there.
            next_line = (ev.bit_cnt < CNT_FORCE) ? ev.msb : 1'b1; // [RULE_01] [RULE_11]
          end
          if (conv_cnt == 32'(UPDATE_START)) begin
            next_line  = 1'b1; // [RULE_10] [RULE_12]
            next_state = ST_CONVERT;
          end
          if (conv_cnt == 32'(CONV_CYCLES - 1)) begin
            next_conv_cnt = '0; // [RULE_07]
            if (settle != 2'h0) begin
              next_settle = settle - 2'h1;
            end else begin
              ev.load      = 1'b1; // [RULE_08]
              next_line    = 1'b0;
              next_state   = ST_READY;
              next_results = results + 32'h1;
            end
          end
        end
      end
      default: begin
        next_state = ST_CAL;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state    <= ST_CAL;
      line     <= 1'b1;
      conv_cnt <= '0;
      cal_cnt  <= '0;
      hold_cnt <= '0;
      settle   <= 2'h0;
      wake_cal <= 1'b0;
      results  <= '0;
    end else begin
      state    <= next_state;
      line     <= next_line;
      conv_cnt <= next_conv_cnt;
      cal_cnt  <= next_cal_cnt;
      hold_cnt <= next_hold_cnt;
      settle   <= next_settle;
      wake_cal <= next_wake_cal;
      results  <= next_results;
    end
  end

  // Status outputs decode the registered state; routing follows the synchronised pins, buffer_on also off in standby; inputs are cut off during calibration.
  assign ready_serial_out      = line;
  assign cal_inputs_disconnect = (state == ST_CAL); // [RULE_17]
  assign standby_active        = (state == ST_STANDBY);
  assign input_pair_select     = ev.pin_level[0]; // [RULE_26]
  assign buffer_on             = ev.pin_level[1] & (state != ST_STANDBY);
  assign temp_sensor_route     = ev.pin_level[2];

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  logic        ack;
  logic        next_ack;
  logic [31:0] next_readdata;
  logic [31:0] last_result;
  logic [31:0] next_last_result;

  // Every access waits exactly one cycle; unmapped reads return zero.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign cal_req = avs_write && ack && avs_address == REG_CONTROL
                   && avs_writedata[CTRL_CAL_POS];

  always_comb begin
    next_ack         = (avs_read | avs_write) & ~ack;
    next_readdata    = avs_readdata;
    next_last_result = ev.load ? 32'(ev.load_data) : last_result;
    if (avs_read && !ack) begin
      case (avs_address)
        REG_STATUS: begin
          next_readdata = '0;
          next_readdata[STAT_LINE_POS] = line;
          next_readdata[STAT_CAL_POS]  = (state == ST_CAL);
          next_readdata[STAT_STBY_POS] = (state == ST_STANDBY);
          next_readdata[STAT_STATE_POS +: 2] = 2'(state);
          next_readdata[STAT_CNT_POS +: COUNT_W] = ev.bit_cnt;
        end
        REG_RESULT: next_readdata = last_result;
        REG_COUNT:  next_readdata = results;
        default:    next_readdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack          <= 1'b0;
      avs_readdata <= '0;
      last_result  <= '0;
    end else begin
      ack          <= next_ack;
      avs_readdata <= next_readdata;
      last_result  <= next_last_result;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_load_drives_low: assert property (ev.load // [RULE_08]
      |=> !ready_serial_out && state == ST_READY)
    else $error("new result did not pull the line low");
  a_msb_first_out: assert property (state == ST_READY && ev.shift_rise // [RULE_01]
      && !cal_trigger && !ev.pin_edge && !standby_go && ev.bit_cnt < CNT_FORCE
      && conv_cnt != 32'(UPDATE_START) |=> ready_serial_out == $past(ev.msb))
    else $error("shifted bit does not match result msb");
  a_force_high: assert property (state == ST_READY && ev.shift_rise && !standby_go // [RULE_11]
      && ev.bit_cnt == CNT_FORCE |=> ready_serial_out)
    else $error("25th clock did not force the line high");
  // Data bits may legally fall during readback, so only a forced-high or converting line counts.
  a_stay_high: assert property (ready_serial_out && !ev.load // [RULE_12]
      && (ev.bit_cnt > CNT_FORCE || state == ST_CONVERT) |=> ready_serial_out)
    else $error("line fell without a new result");
  a_pin_restart: assert property ((state == ST_CONVERT || state == ST_READY) // [RULE_02]
      && ev.pin_edge && !cal_trigger
      |=> ready_serial_out && state == ST_CONVERT && conv_cnt == 0)
    else $error("pin toggle did not restart conversion");
  a_cal_start: assert property ((state == ST_CONVERT || state == ST_READY) // [RULE_14]
      && ev.shift_fall && ev.bit_cnt == CNT_CAL |=> state == ST_CAL)
    else $error("26th falling edge did not start calibration");
  a_cal_isolated: assert property (state == ST_CAL // [RULE_17]
      |-> ready_serial_out && cal_inputs_disconnect)
    else $error("calibration left inputs connected or line low");
  a_standby_high: assert property (state == ST_STANDBY |-> ready_serial_out) // [RULE_21]
    else $error("line low during standby");
  a_wake_on_low: assert property (state == ST_STANDBY && !ev.shift_level // [RULE_22]
      |=> state == ST_CONVERT || state == ST_CAL)
    else $error("shift clock low did not wake the device");
  a_wake_cal: assert property (state == ST_STANDBY && wake_cal && !ev.shift_level // [RULE_25]
      |=> state == ST_CAL)
    else $error("calibration after wakeup was skipped");

  c_result_ready: cover property (ev.load ##1 state == ST_READY);
  c_cal_pattern: cover property (ev.shift_fall && ev.bit_cnt == CNT_CAL);
  c_standby_entry: cover property (state != ST_STANDBY ##1 state == ST_STANDBY);
  c_wake_with_cal: cover property (state == ST_STANDBY && wake_cal ##1 state == ST_CAL);

endmodule

// ===== rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int N = 4
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rstn,
  // Raw pins: bit 0 is the shift clock, bits 1..3 the select pins.
  input  wire logic [N-1:0] raw,
  // Synchronised levels and edges.
  readout_if.sync_side      ev
);
  import adc_readout_pkg::*;

  logic [N-1:0] meta;
  logic [N-1:0] stab;
  logic [N-1:0] prev;
  logic [N-1:0] next_meta;
  logic [N-1:0] next_stab;
  logic [N-1:0] next_prev;

  // Two flops per pin, then a third flop only for edge detection.
  always_comb begin
    next_meta = raw;
    next_stab = meta;
    next_prev = stab;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta <= '0;
      stab <= '0;
      prev <= '0;
    end else begin
      meta <= next_meta;
      stab <= next_stab;
      prev <= next_prev;
    end
  end

  // Any edge on a select pin is reported as one restart pulse.
  assign ev.shift_level = stab[0];
  assign ev.shift_rise  = stab[0] & ~prev[0];
  assign ev.shift_fall  = ~stab[0] & prev[0];
  assign ev.pin_level   = stab[3:1];
  assign ev.pin_edge    = |(stab[3:1] ^ prev[3:1]);

endmodule

// ===== rtl/result_shifter.sv
`timescale 1ns/1ps
module result_shifter (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rstn,
  // Control side.
  readout_if.shift_side sh
);
  import adc_readout_pkg::*;

  logic [RESULT_W-1:0] sr;
  logic [COUNT_W-1:0]  cnt;
  logic [RESULT_W-1:0] next_sr;
  logic [COUNT_W-1:0]  next_cnt;

  // A load wins over a shift; the count saturates so long clock bursts never wrap.
  always_comb begin
    next_sr  = sr;
    next_cnt = cnt;
    if (sh.load) begin
      next_sr  = sh.load_data;
      next_cnt = '0;
    end else if (sh.shift_rise) begin
      if (cnt < COUNT_W'(RESULT_W)) begin
        next_sr = {sr[RESULT_W-2:0], 1'b0}; // [RULE_05]
      end
      if (cnt != CNT_IDLE) begin
        next_cnt = cnt + COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sr  <= '0;
      cnt <= CNT_IDLE;
    end else begin
      sr  <= next_sr;
      cnt <= next_cnt;
    end
  end

  assign sh.msb     = sr[RESULT_W-1];
  assign sh.bit_cnt = cnt;

endmodule

// ===== sim/adc_readout_ctrl_tb.sv
`timescale 1ns/1ps
module adc_readout_ctrl_tb;
  import adc_readout_pkg::*;
  // The ready window must outlast 25 bits plus the standby hold, or a new load
  // would clear the bit count before standby is taken.
  localparam int CONV = 700;
  localparam int CAL  = 300;
  logic                    clk, rstn, rd, wr, wait_req, shift_clk, line;
  logic [3:0]              addr;
  logic [31:0]             wdata, rdata, v, c0;
  logic [2:0]              pins;
  logic signed [RAW_W-1:0] raw;
  logic                    pair, buf_on, temp_route, cal_dis, stby;
  int                      err_count, n_compared, cycles, n, m;
  // The last word ends in a zero, so the 25th clock has a low line to force high.
  logic [25:0]             raws [5] = '{26'h0000000, 26'h0800000, 26'h37FFFFF,
                                        26'h3FFFFFF, 26'h0123456};
  logic [23:0]             exps [5] = '{24'h000000, 24'h7FFFFF, 24'h800000,
                                        24'hFFFFFF, 24'h123456};

  adc_readout_ctrl #(.CONV_CYCLES(CONV), .CAL_CYCLES(CAL)) dut (
    .clk(clk), .rstn(rstn), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_req),
    .shift_clk(shift_clk), .ready_serial_out(line),
    .channel_select_pin(pins[0]), .input_buffer_enable_pin(pins[1]),
    .temp_sensor_enable_pin(pins[2]), .raw_sample(raw), .input_pair_select(pair),
    .buffer_on(buf_on), .temp_sensor_route(temp_route),
    .cal_inputs_disconnect(cal_dis), .standby_active(stby));

  host_model host (.clk(clk), .ready_serial_out(line), .shift_clk(shift_clk));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // A run of about 23k cycles is expected; the ceiling leaves a wide margin.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 50000) begin
      err_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One bus access; the request stands until a rising edge sees waitrequest low,
  // and read data are taken and the request released at that same edge.
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    addr <= a;
    rd <= ~w;
    wr <= w;
    wdata <= wd;
    do begin
      @(posedge clk);
      k++;
    end while (wait_req !== 1'b0 && k < 50);
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) check(0, 1, "bus stall");
  endtask

  task automatic wait_line(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (line !== lvl && cnt < lim) begin
      @(posedge clk);
      cnt++;
    end
    if (cnt >= lim) check(line, lvl, "line wait");
  endtask

  // Waits for a result loaded after this point, so the whole window is ours.
  task automatic fresh();
    wait_line(1'b1, CONV + 50, n);
    wait_line(1'b0, 4 * CONV + CAL, n);
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    pins = 3'h2;
    raw = '0;
    err_count = 0;
    n_compared = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(cal_dis, 1'b1, "power-up cal");
    check(line, 1'b1, "line during cal");
    wait_line(1'b0, CAL + 4 * CONV, n);
    check(cal_dis, 1'b0, "cal ended");
    $display("test power-up done");
    // Each word is loaded after the raw value changed, then read both ways.
    // The raw input is already filtered, so the first word after a step is
    // trusted; a real host would discard three readings here.
    foreach (raws[i]) begin
      @(posedge clk);
      raw <= raws[i];
      fresh();
      host.shift(24, v);
      check(v[23:0], exps[i], "serial word");
      repeat (20) @(posedge clk);
      check(line, exps[i][0], "last bit held");
      bus(REG_RESULT, 1'b0, 32'h0, c0);
      check(c0, {8'h00, exps[i]}, "result reg");
    end
    host.shift(1, v);
    check(v[0], 1'b1, "25th forces high");
    repeat (60) @(posedge clk);
    check(line, 1'b1, "stays high");
    $display("test format done");
    // Result spacing and counting.
    fresh();
    bus(REG_COUNT, 1'b0, 32'h0, c0);
    wait_line(1'b1, CONV + 50, n);
    wait_line(1'b0, CONV + 50, m);
    wait_line(1'b1, CONV + 50, n);
    check(n + m, CONV, "result period");
    bus(REG_COUNT, 1'b0, 32'h0, v);
    check(v, c0 + 1, "result count");
    bus(4'h2, 1'b0, 32'h0, v);
    check(v, 32'h0, "unmapped read");
    $display("test period done");
    // Pin toggles, the last one a channel swap away and back.
    for (int p = 0; p < 4; p++) begin
      fresh();
      @(posedge clk);
      pins[p % 3] <= ~pins[p % 3];
      if (p == 3) begin
        repeat (6) @(posedge clk);
        pins[0] <= ~pins[0];
      end
      wait_line(1'b1, 10, n);
      wait_line(1'b0, 4 * CONV, n);
      check(n > 2 * CONV, 1'b1, "settled restart");
      check({temp_route, buf_on, pair}, pins, "pin routing");
    end
    $display("test pins done");
    // Calibration by clock pattern: nothing after 25, start after the 26th.
    fresh();
    host.shift(25, v);
    repeat (10) @(posedge clk);
    check(cal_dis, 1'b0, "no cal at 25");
    host.shift(1, v);
    repeat (3) @(posedge clk);
    check(cal_dis, 1'b1, "cal at 26th fall");
    bus(REG_STATUS, 1'b0, 32'h0, v);
    check(v[STAT_CAL_POS], 1'b1, "status cal");
    wait_line(1'b0, CAL + 50, n);
    bus(REG_CONTROL, 1'b1, 32'h1, v);
    repeat (5) @(posedge clk);
    check(cal_dis, 1'b1, "cal by register");
    wait_line(1'b0, CAL + 50, n);
    $display("test calibration done");
    // Standby in mid-readback, then standby after 25 bits. The device clock is
    // left running through standby, which the host is free to do.
    for (int s = 0; s < 2; s++) begin
      fresh();
      host.shift(s ? 25 : 3, v);
      host.hold(1'b1);
      repeat (STANDBY_HOLD_CYCLES + 10) @(posedge clk);
      check({stby, line, buf_on}, 3'h6, "standby");
      host.hold(1'b0);
      repeat (10) @(posedge clk);
      check({stby, cal_dis}, {1'b0, s[0]}, "wake");
      wait_line(1'b0, CAL + 4 * CONV, n);
      check(line, 1'b0, "ready after wake");
    end
    $display("test standby done");
    results();
  end

endmodule

// ===== sim/host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host side of the serial link
// ----------------------------------------------------------------
module host_model (
  // Clock.
  input  wire logic clk,
  // Serial line.
  input  wire logic ready_serial_out,
  output logic      shift_clk
);

  // The link idles low between frames.
  initial begin
    shift_clk = 1'b0;
  end

  // Shifts n bits at 800 ns a bit, four clocks high and four low. The line is
  // read late in the low half, because the device moves it a few clocks after
  // each rise and an earlier sample would race its synchroniser.
  task automatic shift(input int n, output logic [31:0] val);
    val = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      shift_clk <= 1'b1;
      repeat (4) @(posedge clk);
      shift_clk <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      val = {val[30:0], ready_serial_out};
    end
  endtask

  // Parks the link at a level, high to ask for standby and low to wake.
  task automatic hold(input logic lvl);
    @(posedge clk);
    shift_clk <= lvl;
  endtask

endmodule
